// [design/back_channel_mode_status.sv]
// Functional notes
// - fast off: select picks 5 or 10 Mbps
// - fast on: 20 Mbps, select ignored
// - rate change flags short back-channel errors
// - auto format resets set, follows aux codes
// - fast enable preset from strap, writable
// - cable select 0 twisted pair, 1 coax
// - bit 2 read-only repeater strap indication
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module back_channel_mode_status (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // axi4-lite write address
  input  wire logic [9:0]  awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  // axi4-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  // axi4-lite write response
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [9:0]  araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  // mode-select pin strap, decoded levels
  input  wire logic        strapFast,
  input  wire logic        strapCoax,
  input  wire logic        strapRepeater,
  // aux data code format hint from the link
  input  wire logic        auxFormatValid,
  input  wire logic [1:0]  auxFormatCode,
  // block outputs
  output var  logic [1:0]  backChannelRate,
  output var  logic        rateSettling,
  output var  logic        coaxSelect,
  output var  logic [1:0]  audioFormat
);
  // ==========================================================
  // strap synchronisers
  logic [2:0] strapMeta_q;
  logic [2:0] strapSync_q;
  always_ff @(posedge clock) begin
    strapMeta_q <= {strapFast, strapCoax, strapRepeater};
    strapSync_q <= strapMeta_q;
  end
  // ==========================================================
  // strap capture after reset release
  logic strapTaken_q;
  logic strapTake;
  logic [2:0] syncAge_q;   // sync chain fill count since release
  assign strapTake = !strapTaken_q && (syncAge_q == 3'h2);
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      syncAge_q    <= 3'h0;
      strapTaken_q <= 1'b0;
    end else begin
      if (syncAge_q != 3'h2) syncAge_q <= syncAge_q + 3'h1;
      if (strapTake) strapTaken_q <= 1'b1;
    end
  end
  // ==========================================================
  // axi write channel capture
  logic       awHeld_q;
  logic       wHeld_q;
  logic [9:0] awAddr_q;
  logic [7:0] wByte_q;
  logic       wLane_q;
  logic       doWrite;
  logic       writeHit;
  assign doWrite  = awHeld_q && wHeld_q && !bvalid;
  assign writeHit = (awAddr_q == rx_mode_pkg::ModeAddr);
  // next holding state, so the ready flops look one cycle ahead
  logic awHeldNext;
  logic wHeldNext;
  logic bvalidNext;
  assign awHeldNext = !doWrite && (awHeld_q || (awvalid && awready));
  assign wHeldNext  = !doWrite && (wHeld_q || (wvalid && wready));
  assign bvalidNext = doWrite || (bvalid && !bready);
  // registered ready: low in reset, each high while its own channel holds nothing and no write response is pending
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      awready <= 1'b0;
      wready  <= 1'b0;
    end else begin
      awready <= !awHeldNext && !bvalidNext;
      wready  <= !wHeldNext && !bvalidNext;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= 10'h000;
      wByte_q  <= 8'h00;
      wLane_q  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_q <= 1'b1;
        wByte_q <= wdata[7:0];
        wLane_q <= wstrb[0];
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
      end
    end
  end
  // write response
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp  <= rx_mode_pkg::RespOkay;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp  <= writeHit ? rx_mode_pkg::RespOkay : rx_mode_pkg::RespSlvErr;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end
  // ==========================================================
  // mode register fields
  logic rateSel_q;
  logic autoFmt_q;
  logic fast_q;
  logic coax_q;
  logic repeater_q;
  logic fieldWrite;
  assign fieldWrite = doWrite && writeHit && wLane_q;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rateSel_q  <= rx_mode_pkg::RateSelReset;
      autoFmt_q  <= rx_mode_pkg::AutoFmtReset;
      fast_q     <= 1'b0;
      coax_q     <= 1'b0;
      repeater_q <= 1'b0;
    end else if (strapTake) begin
      fast_q     <= strapSync_q[2];
      coax_q     <= strapSync_q[1];
      repeater_q <= strapSync_q[0];
    end else if (fieldWrite) begin
      rateSel_q <= wByte_q[rx_mode_pkg::RateSelBit];
      autoFmt_q <= wByte_q[rx_mode_pkg::AutoFmtBit];
      fast_q    <= wByte_q[rx_mode_pkg::FastBit];
      coax_q    <= wByte_q[rx_mode_pkg::CoaxBit];
    end
  end
  // ==========================================================
  // read image, reserved bits 7, 1, 0 zero
  logic [7:0] modeImage;
  always_comb begin
    modeImage = 8'h00;
    modeImage[rx_mode_pkg::RateSelBit]  = rateSel_q;
    modeImage[rx_mode_pkg::AutoFmtBit]  = autoFmt_q;
    modeImage[rx_mode_pkg::FastBit]     = fast_q;
    modeImage[rx_mode_pkg::CoaxBit]     = coax_q;
    modeImage[rx_mode_pkg::RepeaterBit] = repeater_q;
  end
  logic readHit;
  assign readHit = (araddr == rx_mode_pkg::ModeAddr);
  logic rvalidNext;
  assign rvalidNext = (arvalid && arready) || (rvalid && !rready);
  // registered ready: next read only once the answer is taken
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      arready <= 1'b0;
    end else begin
      arready <= !rvalidNext;
    end
  end
  // read channel
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= rx_mode_pkg::RespOkay;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= readHit ? {24'h000000, modeImage} : 32'h0000_0000;
      rresp  <= readHit ? rx_mode_pkg::RespOkay : rx_mode_pkg::RespSlvErr;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
  // ==========================================================
  // back channel rate generator
  rate_bus_if rateBus ();
  assign rateBus.fastEnable = fast_q;
  assign rateBus.rateSelect = rateSel_q;
  back_channel_rate rateGen (
    .clock   (clock),
    .rst_n   (rst_n),
    .rateBus (rateBus.gen)
  );
  // settle window after any rate change
  logic [7:0] settleCnt_q;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      settleCnt_q <= 8'h00;
    end else if (rateBus.rateChange) begin
      settleCnt_q <= 8'(rx_mode_pkg::SettleCycles);
    end else if (settleCnt_q != 8'h00) begin
      settleCnt_q <= settleCnt_q - 8'h01;
    end
  end
  // ==========================================================
  // registered outputs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      backChannelRate <= 2'h0;
      rateSettling    <= 1'b0;
      coaxSelect      <= 1'b0;
      audioFormat     <= 2'h0;
    end else begin
      backChannelRate <= rateBus.rateCode;
      rateSettling    <= rateBus.rateChange || (settleCnt_q != 8'h00);
      coaxSelect      <= coax_q;
      if (autoFmt_q && auxFormatValid) audioFormat <= auxFormatCode;
    end
  end
  // ==========================================================
  // assertions
  // fast enable held over two edges
  sequence fastHeld;
    fast_q ##1 fast_q;
  endsequence
  a_strap_capture_load: assert property (@(posedge clock)
    disable iff (!rst_n)
    strapTake |=> {fast_q, coax_q, repeater_q} == $past(strapSync_q))
    else $error("strap fields not loaded from strap");
  a_reserved_zero: assert property (@(posedge clock)
    disable iff (!rst_n)
    rvalid |-> rdata[7] == 1'b0 && rdata[1:0] == 2'h0)
    else $error("reserved bits read nonzero");
  a_repeater_readonly: assert property (@(posedge clock)
    disable iff (!rst_n)
    strapTaken_q && !strapTake |=> $stable(repeater_q))
    else $error("repeater bit changed");
  a_auto_fmt_follow: assert property (@(posedge clock)
    disable iff (!rst_n)
    autoFmt_q && auxFormatValid |=> audioFormat == $past(auxFormatCode))
    else $error("audio format not taken");
  a_coax_out_track: assert property (@(posedge clock)
    disable iff (!rst_n)
    ##1 coaxSelect == $past(coax_q))
    else $error("coax output mismatch");
  a_fast_write_take: assert property (@(posedge clock)
    disable iff (!rst_n)
    fieldWrite && !strapTake |=>
      fast_q == $past(wByte_q[rx_mode_pkg::FastBit]))
    else $error("fast enable not writable");
  a_settle_after_change: assert property (@(posedge clock)
    disable iff (!rst_n)
    rateBus.rateChange |=> rateSettling [*8])
    else $error("settle window too short");
  a_rate_out_fast: assert property (@(posedge clock)
    disable iff (!rst_n)
    fastHeld |=> backChannelRate == 2'h2)
    else $error("fast rate not driven");
endmodule
`default_nettype wire

// [design/rx_mode_pkg.sv]
`default_nettype none
package rx_mode_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] ModeIndex     = 8'h23;   // register index
  localparam logic [9:0] ModeAddr      = 10'h08c; // byte address = 4*index
  localparam int         AddrWidth     = 10;
  // ==========================================================
  // field positions
  localparam int RateSelBit  = 6;
  localparam int AutoFmtBit  = 5;
  localparam int FastBit     = 4;
  localparam int CoaxBit     = 3;
  localparam int RepeaterBit = 2;
  // ==========================================================
  // reset values
  localparam logic RateSelReset = 1'b0;
  localparam logic AutoFmtReset = 1'b1;
  // ==========================================================
  // back channel rates, in Mbps
  localparam int RateSlowMbps = 5;
  localparam int RateMidMbps  = 10;
  localparam int RateFastMbps = 20;
  localparam int ClockMhz     = 100;
  // settle window after a rate change, ns, and its cycle count
  localparam int SettleNs     = 1000;
  localparam int SettleCycles = (SettleNs * ClockMhz + 999) / 1000;
  // ==========================================================
  // back channel rate codes, as driven on backChannelRate
  typedef enum logic [1:0] {
    RateCodeSlow,
    RateCodeMid,
    RateCodeFast
  } rate_code_t;
  // axi response codes
  localparam logic [1:0] RespOkay   = 2'b00;
  localparam logic [1:0] RespSlvErr = 2'b10;
endpackage
`default_nettype wire

// [design/rate_bus_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface rate_bus_if;
  logic                      fastEnable;
  logic                      rateSelect;
  rx_mode_pkg::rate_code_t   rateCode;
  logic                      rateChange;
  modport ctrl (output fastEnable, output rateSelect, input rateCode,
                input rateChange);
  modport gen  (input fastEnable, input rateSelect, output rateCode,
                output rateChange);
endinterface
`default_nettype wire

// [design/back_channel_rate.sv]
`timescale 1ns/1ns
`default_nettype none
module back_channel_rate (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // settings in, rate out
  rate_bus_if.gen   rateBus
);
  // ==========================================================
  // rate decode
  rx_mode_pkg::rate_code_t rateD;
  rx_mode_pkg::rate_code_t rateQ;
  // fast wins over the select
  assign rateD = rateBus.fastEnable ? rx_mode_pkg::RateCodeFast :
                 (rateBus.rateSelect ? rx_mode_pkg::RateCodeMid
                                     : rx_mode_pkg::RateCodeSlow);
  assign rateBus.rateCode   = rateQ;
  assign rateBus.rateChange = (rateD != rateQ);
  // registered rate
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rateQ <= rx_mode_pkg::RateCodeSlow;
    end else begin
      rateQ <= rateD;
    end
  end
  a_rate_fast_wins: assert property (@(posedge clock)
    disable iff (!rst_n)
    rateBus.fastEnable |=> rateQ == rx_mode_pkg::RateCodeFast)
    else $error("fast enable did not select fast rate");
  a_rate_select_slow: assert property (@(posedge clock)
    disable iff (!rst_n)
    !rateBus.fastEnable |=> rateQ == ($past(rateBus.rateSelect) ?
      rx_mode_pkg::RateCodeMid : rx_mode_pkg::RateCodeSlow))
    else $error("rate select mismatch");
endmodule
`default_nettype wire

// [verification/remote_link_model.sv]
`timescale 1ns/1ns
`default_nettype none
module remote_link_model (
  // clock
  input  wire logic       clock,
  // aux format hint toward the block
  output var  logic       auxFormatValid,
  output var  logic [1:0] auxFormatCode
);
  logic autoAck;
  // ==========================================================
  // idle: code line shows the inverse of the last code sent
  initial begin
    auxFormatValid = 1'b0;
    auxFormatCode  = 2'h0;
    autoAck        = 1'b0;
  end
  // auto-ack set before any rate change is requested
  task automatic prepare_rate_change();
    autoAck = 1'b1;
  endtask
  // one cycle of a valid format code
  task automatic send_code(input logic [1:0] code);
    @(posedge clock);
    auxFormatValid <= 1'b1;
    auxFormatCode  <= code;
    @(posedge clock);
    auxFormatValid <= 1'b0;
    auxFormatCode  <= ~code;
  endtask
endmodule
`default_nettype wire

// [verification/back_channel_mode_status_test.sv]
`timescale 1ns/1ns
`default_nettype none
module back_channel_mode_status_test;
  // ==========================================================
  // signals
  logic        clock, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, rateSettling;
  logic        strapFast, strapCoax, strapRepeater, coaxSelect;
  logic        auxFormatValid;
  logic [9:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, auxFormatCode, backChannelRate, audioFormat;
  logic [1:0]  resp;
  logic [31:0] rd;
  logic [3:0]  strb = 4'h1;
  int          n_errors, n_checks;
  localparam logic [9:0] Bad = 10'h090;
  // ==========================================================
  // clock and initial drive
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    {strapFast, strapCoax, strapRepeater} = 3'h7;
  end
  back_channel_mode_status u_dut (
    .clock(clock), .rst_n(rst_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .strapFast(strapFast), .strapCoax(strapCoax),
    .strapRepeater(strapRepeater),
    .auxFormatValid(auxFormatValid), .auxFormatCode(auxFormatCode),
    .backChannelRate(backChannelRate), .rateSettling(rateSettling),
    .coaxSelect(coaxSelect), .audioFormat(audioFormat)
  );
  remote_link_model u_far (.clock(clock), .auxFormatValid(auxFormatValid),
    .auxFormatCode(auxFormatCode));
  // ==========================================================
  // compare and close
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // axi4-lite master cycles
  task automatic axi_write(input logic [9:0] a, input logic [7:0] d);
    logic aT, wT, bT;
    int   n;
    bT = 1'b0;
    n = 0;
    @(posedge clock);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= strb;
    {awvalid, wvalid, bready} <= 3'h7;
    while (!bT && n < 200) begin
      @(negedge clock);
      aT = awvalid && awready;
      wT = wvalid && wready;
      bT = bvalid;
      resp = bresp;
      @(posedge clock);
      if (aT) awvalid <= 1'b0;
      if (wT) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!bT) check(32'h0, 32'h1);
  endtask
  task automatic axi_read(input logic [9:0] a);
    logic aT, rT;
    int   n;
    rT = 1'b0;
    n = 0;
    @(posedge clock);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    while (!rT && n < 200) begin
      @(negedge clock);
      aT = arvalid && arready;
      rT = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge clock);
      if (aT) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!rT) check(32'h0, 32'h1);
  endtask
  // ==========================================================
  // scenarios
  task automatic s_reset();
    axi_read(rx_mode_pkg::ModeAddr);
    check(rd, 32'h3c);
    check(coaxSelect, 1'b1);
    check(backChannelRate, 2'h2);
  endtask
  task automatic s_rates();
    logic [7:0] v;
    u_far.prepare_rate_change();
    check(u_far.autoAck, 1'b1);
    for (int i = 0; i < 4; i++) begin
      v = {1'b1, i[0], 1'b1, i[1], 4'h0};
      axi_write(rx_mode_pkg::ModeAddr, v);
      repeat (3) @(posedge clock);
      check(rateSettling, 1'b1);
      check(backChannelRate, i[1] ? 2'h2 : {1'b0, i[0]});
      check(coaxSelect, 1'b0);
    end
    // settle window must end after the last change
    repeat (120) @(posedge clock);
    check(rateSettling, 1'b0);
  endtask
  task automatic s_reserved();
    strapFast <= 1'b0;
    strapRepeater <= 1'b0;
    axi_write(rx_mode_pkg::ModeAddr, 8'h93);
    repeat (6) @(posedge clock);
    check(backChannelRate, 2'h2);
    axi_read(rx_mode_pkg::ModeAddr);
    check(rd, 32'h14);
    check(rd[rx_mode_pkg::RepeaterBit], 1'b1);
  endtask
  task automatic s_unmapped();
    axi_write(Bad, 8'hff);
    check(resp, rx_mode_pkg::RespSlvErr);
    axi_read(Bad);
    check(resp, rx_mode_pkg::RespSlvErr);
    check(rd, 32'h0);
    // strobe off: accepted, register untouched
    strb = 4'h0;
    axi_write(rx_mode_pkg::ModeAddr, 8'hff);
    strb = 4'h1;
    check(resp, rx_mode_pkg::RespOkay);
    axi_read(rx_mode_pkg::ModeAddr);
    check(rd, 32'h14);
  endtask
  task automatic s_audio();
    axi_write(rx_mode_pkg::ModeAddr, 8'h20);
    u_far.send_code(2'h2);
    repeat (2) @(posedge clock);
    check(audioFormat, 2'h2);
    axi_write(rx_mode_pkg::ModeAddr, 8'h00);
    u_far.send_code(2'h1);
    repeat (2) @(posedge clock);
    check(audioFormat, 2'h2);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(posedge clock);
    s_reset();
    s_rates();
    s_reserved();
    s_unmapped();
    s_audio();
    test_done();
  end
  initial begin
    #100000;
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire
